// [pxm_pkg.sv]
// package for the port crossbar and match block
// assumes an 8-bit special-function register bus driven by the core
package pxm_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ROUTE_A   = 8'hE1; // crossbar_route_a
    localparam logic [7:0] ADDR_ROUTE_B   = 8'hE2; // crossbar_route_b
    localparam logic [7:0] ADDR_PORT_ZERO = 8'h80; // port_zero_reg
    localparam logic [7:0] ADDR_PORT_ONE  = 8'h90; // port_one_reg
    localparam logic [7:0] ADDR_P0_CMP    = 8'hD4; // port_zero_compare
    localparam logic [7:0] ADDR_P0_MASK   = 8'hD3; // port_zero_mask
    localparam logic [7:0] ADDR_P1_CMP    = 8'hD6; // port_one_compare
    localparam logic [7:0] ADDR_P1_MASK   = 8'hD5; // port_one_mask
    localparam logic [7:0] ADDR_IRQ_EN2   = 8'hE7; // extended_irq_enable_two
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ROUTE      = 8'h00;
    localparam logic [7:0] RST_PORT       = 8'hFF;
    localparam logic [7:0] RST_MASK       = 8'h00;
    localparam logic [7:0] RST_CMP        = 8'hFF;
    localparam logic [7:0] RST_IRQ_EN2    = 8'h00;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam logic [7:0] ROUTE_A_RW     = 8'h3F; // bits 7:6 reserved
    localparam logic [7:0] ROUTE_B_RW     = 8'hFB; // bit 2 reserved
    localparam int         RA_UART        = 0;
    localparam int         RA_SERIAL      = 1;
    localparam int         RA_LIN         = 2;
    localparam int         RA_CLKOUT      = 3;
    localparam int         RA_CMP         = 4;
    localparam int         RA_CMP_ASYNC   = 5;
    localparam int         RB_ECI         = 3;
    localparam int         RB_TIMER_A     = 4;
    localparam int         RB_TIMER_B     = 5;
    localparam int         RB_XBAR_ON     = 6;
    localparam int         RB_PULLUP_DIS  = 7;
    localparam int         IE2_MATCH      = 1;
    localparam int         BIT_IDX_W      = 3;
    // ------------------------------------------------------------
    // counter-array output select codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PXM_CEX_NONE  = 2'h0,
        PXM_CEX_ONE   = 2'h1,
        PXM_CEX_TWO   = 2'h2,
        PXM_CEX_THREE = 2'h3
    } pxm_cex_sel_t;
endpackage : pxm_pkg

// [pxm_match.sv]
// mismatch compare for one 8-bit port
// assumes pin levels are synchronous to CLK
`timescale 1ns/1ps
module pxm_match #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // compare inputs
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic [WIDTH-1:0] cmp,
    // registered mismatch
    output logic                  mismatch
);
    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("pxm_match: WIDTH must be positive");
    end
    // differ wherever mask selects a bit that disagrees
    wire logic mismatch_nxt = |((pins ^ cmp) & mask); // R6 R7

    // register so the result is glitch free
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) mismatch <= 1'b0;
        else        mismatch <= mismatch_nxt;
    end

    mismatch_track_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
        mismatch == $past((pins & mask) != (cmp & mask))) else $error("mismatch stale");
endmodule : pxm_match

// [pxm_top.sv]
// port crossbar routing, general-purpose port latches and port match
// assumes a core SFR bus: one-cycle write strobes, byte or bit form,
// and a read-modify-write flag asserted with the read strobe
//
// How it works
// R1 - unrouted pins remain software port I/O
// R2 - ports take byte and single-bit writes
// R3 - writes held in latch driving pins
// R4 - plain reads return live pin levels
// R5 - read-modify-write reads return latch value
// R6 - masked pins differing from compare raise match
// R7 - match watches pins regardless of routing
// R8 - match interrupt only when enable set
// R9 - match wakes suspended oscillator always
// R10 - crossbar off: inputs only, drivers disabled
// R11 - weak pull-up on open-drain highs unless disabled
// R12 - routing bits route signal; reserved read zero
// R13 - two-bit field routes zero to three outputs
`timescale 1ns/1ps
module pxm_top
    import pxm_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_B,
    // sfr bus
    input  wire logic [7:0]        SFR_ADDR,
    input  wire logic [7:0]        SFR_WDATA,
    input  wire logic              SFR_WR,
    input  wire logic              SFR_BIT_WR,
    input  wire logic [2:0]        SFR_BIT_SEL,
    input  wire logic              SFR_RD,
    input  wire logic              SFR_RMW,
    output logic [7:0]             SFR_RDATA,
    // port pins and per-pin modes from the mode registers outside
    input  wire logic [PORT_W-1:0] P0_PIN_IN,
    input  wire logic [PORT_W-1:0] P1_PIN_IN,
    input  wire logic [PORT_W-1:0] P0_ANALOG,
    input  wire logic [PORT_W-1:0] P1_ANALOG,
    input  wire logic [PORT_W-1:0] P0_PUSH_PULL,
    input  wire logic [PORT_W-1:0] P1_PUSH_PULL,
    input  wire logic [PORT_W-1:0] P0_PERIPH_SEL,
    input  wire logic [PORT_W-1:0] P1_PERIPH_SEL,
    input  wire logic [PORT_W-1:0] P0_PERIPH_OUT,
    input  wire logic [PORT_W-1:0] P1_PERIPH_OUT,
    // pin drive
    output logic [PORT_W-1:0]      P0_PIN_OUT,
    output logic [PORT_W-1:0]      P1_PIN_OUT,
    output logic [PORT_W-1:0]      P0_PIN_OE,
    output logic [PORT_W-1:0]      P1_PIN_OE,
    output logic [PORT_W-1:0]      P0_PULLUP,
    output logic [PORT_W-1:0]      P1_PULLUP,
    // routing enables to the crossbar decoder
    output logic                   XBAR_ON,
    output logic                   UART_ROUTE,
    output logic                   SERIAL_PERIPH_ROUTE,
    output logic                   LIN_ROUTE,
    output logic                   CLOCK_OUT_ROUTE,
    output logic                   COMPARATOR_OUT_ROUTE,
    output logic                   COMPARATOR_ASYNC_OUT_ROUTE,
    output logic                   COUNTER_ARRAY_EXT_IN_ROUTE,
    output logic                   TIMER_A_INPUT_ROUTE,
    output logic                   TIMER_B_INPUT_ROUTE,
    output logic [2:0]             CEX_ROUTE,
    // match event
    output logic                   MATCH_IRQ,
    output logic                   OSC_WAKE
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    if (PORT_W != 8) begin : g_bad_width
        $error("pxm_top: PORT_W must be 8");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]        route_a_r;   // crossbar_route_a
    logic [7:0]        route_b_r;   // crossbar_route_b
    logic [7:0]        p0_latch_r;  // port_zero_reg latch
    logic [7:0]        p1_latch_r;  // port_one_reg latch
    logic [7:0]        p0_mask_r;   // port_zero_mask
    logic [7:0]        p0_cmp_r;    // port_zero_compare
    logic [7:0]        p1_mask_r;   // port_one_mask
    logic [7:0]        p1_cmp_r;    // port_one_compare
    logic [7:0]        ie2_r;       // extended_irq_enable_two
    logic              p0_mis;      // masked mismatch, port zero
    logic              p1_mis;      // masked mismatch, port one

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic hit_ra  = SFR_ADDR == ADDR_ROUTE_A;
    wire logic hit_rb  = SFR_ADDR == ADDR_ROUTE_B;
    wire logic hit_p0  = SFR_ADDR == ADDR_PORT_ZERO;
    wire logic hit_p1  = SFR_ADDR == ADDR_PORT_ONE;
    wire logic hit_m0  = SFR_ADDR == ADDR_P0_MASK;
    wire logic hit_c0  = SFR_ADDR == ADDR_P0_CMP;
    wire logic hit_m1  = SFR_ADDR == ADDR_P1_MASK;
    wire logic hit_c1  = SFR_ADDR == ADDR_P1_CMP;
    wire logic hit_ie2 = SFR_ADDR == ADDR_IRQ_EN2;

    // byte write goes whole; bit write touches only the selected bit
    wire logic [7:0] bit_onehot = 8'h01 << SFR_BIT_SEL;
    wire logic [7:0] wr_lanes   = SFR_WR ? 8'hFF : (SFR_BIT_WR ? bit_onehot : 8'h00); // R2
    wire logic [7:0] bit_data   = {8{SFR_WDATA[0]}};
    wire logic [7:0] wr_val     = SFR_WR ? SFR_WDATA : bit_data;

    // merge new bits into an old register value
    function automatic logic [7:0] pxm_merge(input logic [7:0] old_v, input logic [7:0] lanes,
                                             input logic [7:0] val);
        pxm_merge = (old_v & ~lanes) | (val & lanes);
    endfunction : pxm_merge

    wire logic [7:0] ra_nxt  = hit_ra ? pxm_merge(route_a_r, wr_lanes, wr_val) & ROUTE_A_RW
                                      : route_a_r; // R12
    wire logic [7:0] rb_nxt  = hit_rb ? pxm_merge(route_b_r, wr_lanes, wr_val) & ROUTE_B_RW
                                      : route_b_r; // R12
    wire logic [7:0] p0_nxt  = hit_p0 ? pxm_merge(p0_latch_r, wr_lanes, wr_val) : p0_latch_r; // R3
    wire logic [7:0] p1_nxt  = hit_p1 ? pxm_merge(p1_latch_r, wr_lanes, wr_val) : p1_latch_r; // R3
    wire logic [7:0] m0_nxt  = hit_m0 ? pxm_merge(p0_mask_r, wr_lanes, wr_val) : p0_mask_r;
    wire logic [7:0] c0_nxt  = hit_c0 ? pxm_merge(p0_cmp_r, wr_lanes, wr_val) : p0_cmp_r;
    wire logic [7:0] m1_nxt  = hit_m1 ? pxm_merge(p1_mask_r, wr_lanes, wr_val) : p1_mask_r;
    wire logic [7:0] c1_nxt  = hit_c1 ? pxm_merge(p1_cmp_r, wr_lanes, wr_val) : p1_cmp_r;
    wire logic [7:0] ie2_nxt = hit_ie2 ? pxm_merge(ie2_r, wr_lanes, wr_val) : ie2_r;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // latches only change on a write, so pins hold between writes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            route_a_r  <= RST_ROUTE;
            route_b_r  <= RST_ROUTE;
            p0_latch_r <= RST_PORT;
            p1_latch_r <= RST_PORT;
            p0_mask_r  <= RST_MASK;
            p0_cmp_r   <= RST_CMP;
            p1_mask_r  <= RST_MASK;
            p1_cmp_r   <= RST_CMP;
            ie2_r      <= RST_IRQ_EN2;
        end else begin
            route_a_r  <= ra_nxt;
            route_b_r  <= rb_nxt;
            p0_latch_r <= p0_nxt;
            p1_latch_r <= p1_nxt;
            p0_mask_r  <= m0_nxt;
            p0_cmp_r   <= c0_nxt;
            p1_mask_r  <= m1_nxt;
            p1_cmp_r   <= c1_nxt;
            ie2_r      <= ie2_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // analog pins read zero on a plain read; rmw sees the latch, plain read the pins
    wire logic [7:0] p0_live = P0_PIN_IN & ~P0_ANALOG; // R4
    wire logic [7:0] p1_live = P1_PIN_IN & ~P1_ANALOG; // R4
    wire logic [7:0] p0_rd   = SFR_RMW ? p0_latch_r : p0_live; // R5
    wire logic [7:0] p1_rd   = SFR_RMW ? p1_latch_r : p1_live; // R5
    wire logic [7:0] rdata_nxt =
        !SFR_RD  ? SFR_RDATA  :
        hit_ra   ? route_a_r  :
        hit_rb   ? route_b_r  :
        hit_p0   ? p0_rd      :
        hit_p1   ? p1_rd      :
        hit_m0   ? p0_mask_r  :
        hit_c0   ? p0_cmp_r   :
        hit_m1   ? p1_mask_r  :
        hit_c1   ? p1_cmp_r   :
        hit_ie2  ? ie2_r      : 8'h00; // unmapped reads zero

    // one-cycle read latency, data holds until the next read
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) SFR_RDATA <= 8'h00;
        else        SFR_RDATA <= rdata_nxt;
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    wire logic       xbar_on = route_b_r[RB_XBAR_ON];
    wire logic       pu_dis  = route_b_r[RB_PULLUP_DIS];
    // routed pins take the peripheral, the rest take the latch
    wire logic [7:0] p0_val = (P0_PERIPH_SEL & P0_PERIPH_OUT) | (~P0_PERIPH_SEL & p0_latch_r); // R1
    wire logic [7:0] p1_val = (P1_PERIPH_SEL & P1_PERIPH_OUT) | (~P1_PERIPH_SEL & p1_latch_r); // R1
    // open-drain drives low only; push-pull drives both levels
    wire logic [7:0] p0_oe  = {8{xbar_on}} & ~P0_ANALOG & (P0_PUSH_PULL | ~p0_val); // R10
    wire logic [7:0] p1_oe  = {8{xbar_on}} & ~P1_ANALOG & (P1_PUSH_PULL | ~p1_val); // R10
    // undriven open-drain pins float high through the pull-up unless pull-ups are disabled, which keeps them readable
    wire logic [7:0] p0_pu  = {8{~pu_dis}} & ~P0_PUSH_PULL & ~P0_ANALOG & ~p0_oe; // R11
    wire logic [7:0] p1_pu  = {8{~pu_dis}} & ~P1_PUSH_PULL & ~P1_ANALOG & ~p1_oe; // R11
    wire logic [1:0] cex_code = route_b_r[1:0];
    logic [2:0]      cex_nxt;
    always_comb begin
        case (pxm_cex_sel_t'(cex_code)) // R13
            PXM_CEX_NONE:  cex_nxt = 3'h0;
            PXM_CEX_ONE:   cex_nxt = 3'h1;
            PXM_CEX_TWO:   cex_nxt = 3'h3;
            PXM_CEX_THREE: cex_nxt = 3'h7;
            default:       cex_nxt = 3'h0;
        endcase
    end

    // ------------------------------------------------------------
    // match compare
    // ------------------------------------------------------------
    pxm_match #(.WIDTH(PORT_W)) u_m0 (
        .clk      (CLK),
        .rst_b    (RST_B),
        .pins     (P0_PIN_IN),
        .mask     (p0_mask_r),
        .cmp      (p0_cmp_r),
        .mismatch (p0_mis)
    );
    pxm_match #(.WIDTH(PORT_W)) u_m1 (
        .clk      (CLK),
        .rst_b    (RST_B),
        .pins     (P1_PIN_IN),
        .mask     (p1_mask_r),
        .cmp      (p1_cmp_r),
        .mismatch (p1_mis)
    );
    wire logic match_evt = p0_mis | p1_mis; // R6 R7

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            {P0_PIN_OUT, P1_PIN_OUT, P0_PIN_OE, P1_PIN_OE} <= '0;
            {P0_PULLUP, P1_PULLUP, CEX_ROUTE} <= '0;
            {XBAR_ON, UART_ROUTE, SERIAL_PERIPH_ROUTE, LIN_ROUTE} <= '0;
            {CLOCK_OUT_ROUTE, COMPARATOR_OUT_ROUTE, COMPARATOR_ASYNC_OUT_ROUTE} <= '0;
            {COUNTER_ARRAY_EXT_IN_ROUTE, TIMER_A_INPUT_ROUTE, TIMER_B_INPUT_ROUTE} <= '0;
            {MATCH_IRQ, OSC_WAKE} <= '0;
        end else begin
            P0_PIN_OUT <= p0_val;
            P1_PIN_OUT <= p1_val;
            P0_PIN_OE  <= p0_oe;
            P1_PIN_OE  <= p1_oe;
            P0_PULLUP  <= p0_pu;
            P1_PULLUP  <= p1_pu;
            CEX_ROUTE  <= cex_nxt;
            XBAR_ON    <= xbar_on;
            UART_ROUTE                 <= route_a_r[RA_UART];    // R12
            SERIAL_PERIPH_ROUTE        <= route_a_r[RA_SERIAL];
            LIN_ROUTE                  <= route_a_r[RA_LIN];
            CLOCK_OUT_ROUTE            <= route_a_r[RA_CLKOUT];
            COMPARATOR_OUT_ROUTE       <= route_a_r[RA_CMP];
            COMPARATOR_ASYNC_OUT_ROUTE <= route_a_r[RA_CMP_ASYNC];
            COUNTER_ARRAY_EXT_IN_ROUTE <= route_b_r[RB_ECI];
            TIMER_A_INPUT_ROUTE        <= route_b_r[RB_TIMER_A];
            TIMER_B_INPUT_ROUTE        <= route_b_r[RB_TIMER_B];
            MATCH_IRQ  <= match_evt & ie2_r[IE2_MATCH]; // R8
            OSC_WAKE   <= match_evt;                    // R9
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    xbar_off_oe_a: assert property (@(posedge CLK) disable iff (!RST_B) // R10
        !route_b_r[RB_XBAR_ON] |=> (P0_PIN_OE == 8'h00 && P1_PIN_OE == 8'h00))
        else $error("driver on with crossbar off");
    irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_B) // R8
        MATCH_IRQ |-> ($past(ie2_r[IE2_MATCH]) && OSC_WAKE)) else $error("irq not gated");
    wake_follows_a: assert property (@(posedge CLK) disable iff (!RST_B) // R9
        (p0_mis || p1_mis) |=> OSC_WAKE) else $error("no wake on match");
    rmw_latch_a: assert property (@(posedge CLK) disable iff (!RST_B) // R5
        (SFR_RD && SFR_RMW && hit_p0) |=> SFR_RDATA == $past(p0_latch_r))
        else $error("rmw read wrong");
    pin_read_a: assert property (@(posedge CLK) disable iff (!RST_B) // R4
        (SFR_RD && !SFR_RMW && hit_p1) |=> SFR_RDATA == $past(p1_live))
        else $error("pin read wrong");
    bit_write_a: assert property (@(posedge CLK) disable iff (!RST_B) // R2
        (SFR_BIT_WR && !SFR_WR && hit_p0) |=>
        ((p0_latch_r ^ $past(p0_latch_r)) & ~$past(bit_onehot)) == 8'h00)
        else $error("bit write spilled");
    latch_hold_a: assert property (@(posedge CLK) disable iff (!RST_B) // R3
        !(hit_p1 && (SFR_WR || SFR_BIT_WR)) |=> $stable(p1_latch_r))
        else $error("latch changed");
    reserved_zero_a: assert property (@(posedge CLK) disable iff (!RST_B) // R12
        (route_a_r[7:6] == 2'h0) && !route_b_r[2]) else $error("reserved set");
    cex_map_a: assert property (@(posedge CLK) disable iff (!RST_B) // R13
        (route_b_r[1:0] == 2'h2) |=> CEX_ROUTE == 3'h3) else $error("cex map");
    pullup_a: assert property (@(posedge CLK) disable iff (!RST_B) // R11
        route_b_r[RB_PULLUP_DIS] |=> (P0_PULLUP == 8'h00 && P1_PULLUP == 8'h00))
        else $error("pull-up on while disabled");
    match_c: cover property (@(posedge CLK) disable iff (!RST_B) MATCH_IRQ);
    wake_only_c: cover property (@(posedge CLK) disable iff (!RST_B) OSC_WAKE && !MATCH_IRQ);
    rmw_c: cover property (@(posedge CLK) disable iff (!RST_B) SFR_RD && SFR_RMW && hit_p0);
    drive_c: cover property (@(posedge CLK) disable iff (!RST_B) |P0_PIN_OE);
endmodule : pxm_top

// [pxm_pin_model.sv]
// pin-side model for the port crossbar and match block: resolves each port pin
// assumes the bench supplies the level that the outside world puts on an idle pin
`timescale 1ns/1ps
module pxm_pin_model #(
    parameter int W = 8 // pins per port
) (
    // drive from the block
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    // level driven from outside the chip
    input  wire logic [W-1:0] ext_level,
    // level seen back at the pin receivers
    output logic [W-1:0]      pin_in
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // a driven pin shows the driven value; an idle pin follows the outside level,
    // so an open-drain low always wins over the outside high (wired-and)
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pxm_pin_model

// [port_crossbar_and_match_test.sv]
// self-checking bench for the port crossbar and match block
// assumes strobes taken on the rising edge
`timescale 1ns/1ps
module port_crossbar_and_match_test;
    import pxm_pkg::*;
    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic       clk, rst_b;                    // clock and active-low reset
    logic [7:0] addr, wdata, rdata;            // core bus
    logic       wr, bwr, rd, rmw;              // core bus strobes
    logic [2:0] bsel;                          // bit select for bit writes
    logic [7:0] p0_in, p1_in, p0_ext, p1_ext;  // pin levels and outside levels
    logic [7:0] p0_an, p1_an, p0_pp, p1_pp;    // per-pin modes
    logic [7:0] p0_sel, p1_sel, p0_pout, p1_pout;
    logic [7:0] p0_out, p1_out, p0_oe, p1_oe, p0_pu, p1_pu;
    logic       xbar, r_uart, r_ser, r_lin, r_clk, r_cmp, r_cmpa, r_eci, r_ta, r_tb;
    logic [2:0] cex;                           // counter-array output thermometer
    logic       irq, wake;                     // match event outputs
    int         num_errors, tests_run;
    // ------------------------------------------------------------
    // design and pin models
    // ------------------------------------------------------------
    pxm_top dut_u (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_BIT_WR(bwr), .SFR_BIT_SEL(bsel), .SFR_RD(rd), .SFR_RMW(rmw),
        .SFR_RDATA(rdata), .P0_PIN_IN(p0_in), .P1_PIN_IN(p1_in), .P0_ANALOG(p0_an),
        .P1_ANALOG(p1_an), .P0_PUSH_PULL(p0_pp), .P1_PUSH_PULL(p1_pp),
        .P0_PERIPH_SEL(p0_sel), .P1_PERIPH_SEL(p1_sel), .P0_PERIPH_OUT(p0_pout),
        .P1_PERIPH_OUT(p1_pout), .P0_PIN_OUT(p0_out), .P1_PIN_OUT(p1_out),
        .P0_PIN_OE(p0_oe), .P1_PIN_OE(p1_oe), .P0_PULLUP(p0_pu), .P1_PULLUP(p1_pu),
        .XBAR_ON(xbar), .UART_ROUTE(r_uart), .SERIAL_PERIPH_ROUTE(r_ser),
        .LIN_ROUTE(r_lin), .CLOCK_OUT_ROUTE(r_clk), .COMPARATOR_OUT_ROUTE(r_cmp),
        .COMPARATOR_ASYNC_OUT_ROUTE(r_cmpa), .COUNTER_ARRAY_EXT_IN_ROUTE(r_eci),
        .TIMER_A_INPUT_ROUTE(r_ta), .TIMER_B_INPUT_ROUTE(r_tb), .CEX_ROUTE(cex),
        .MATCH_IRQ(irq), .OSC_WAKE(wake));
    pxm_pin_model #(.W(8)) pins0_u (.pin_out(p0_out), .pin_oe(p0_oe), .ext_level(p0_ext),
        .pin_in(p0_in));
    pxm_pin_model #(.W(8)) pins1_u (.pin_out(p1_out), .pin_oe(p1_oe), .ext_level(p1_ext),
        .pin_in(p1_in));
    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // cuts a hang short; the whole run needs far fewer cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end
    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // byte write; strobe up for exactly one rising edge
    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_b
    // single-bit write; the value rides on bit 0 of the write data
    task automatic wr_bit(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(negedge clk);
        addr = a;
        bsel = s;
        wdata = {7'h00, v};
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask : wr_bit
    // read, plain or read-modify-write; data is registered at the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] exp,
                          input string msg);
        @(negedge clk);
        addr = a;
        rmw = m;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        rmw = 1'b0;
        chk(rdata, exp, msg);
    endtask : rd_chk
    // lets register, output and match flops land
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask : settle
    task automatic results;
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {addr, wdata, wr, bwr, rd, rmw, bsel} = '0;
        {p0_an, p1_an, p0_pp, p1_pp, p0_sel, p1_sel, p0_pout, p1_pout} = '0;
        p0_ext = 8'hFF;
        p1_ext = 8'h00;
        num_errors = 0;
        tests_run = 0;
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        // reset values of the register table
        rd_chk(ADDR_ROUTE_A, 1'b0, RST_ROUTE, "route a reset");
        rd_chk(ADDR_ROUTE_B, 1'b0, RST_ROUTE, "route b reset");
        rd_chk(ADDR_PORT_ZERO, 1'b1, RST_PORT, "latch reset");
        rd_chk(ADDR_P0_CMP, 1'b0, RST_CMP, "compare reset");
        rd_chk(ADDR_P0_MASK, 1'b0, RST_MASK, "mask reset");
        rd_chk(ADDR_IRQ_EN2, 1'b0, RST_IRQ_EN2, "enable reset");
        // reserved bits stay zero, routing copies follow the bits
        wr_b(ADDR_ROUTE_A, 8'hFF);
        rd_chk(ADDR_ROUTE_A, 1'b0, 8'h3F, "route a reserved");
        wr_b(ADDR_ROUTE_A, 8'h15);
        settle();
        chk({2'h0, r_cmpa, r_cmp, r_clk, r_lin, r_ser, r_uart}, 8'h15, "route a outs");
        wr_b(ADDR_ROUTE_B, 8'hFF);
        rd_chk(ADDR_ROUTE_B, 1'b0, 8'hFB, "route b reserved");
        settle();
        chk({4'h0, xbar, r_tb, r_ta, r_eci}, 8'h0F, "route b outs");
        // every counter-array output code, crossbar left off
        for (int i = 0; i < 4; i++) begin
            wr_b(ADDR_ROUTE_B, 8'(i));
            settle();
            chk({5'h00, cex}, (8'h01 << i) - 8'h01, "cex thermometer");
        end
        // crossbar off: a low latch must not drive
        wr_b(ADDR_PORT_ZERO, 8'h00);
        settle();
        chk(p0_oe, 8'h00, "drivers while off");
        wr_b(ADDR_ROUTE_B, 8'h40);
        settle();
        chk(p0_oe, 8'hFF, "open-drain lows drive");
        // byte then bit writes held in the latch
        wr_b(ADDR_PORT_ZERO, 8'hA5);
        wr_bit(ADDR_PORT_ZERO, 3'h1, 1'b1);
        wr_bit(ADDR_PORT_ZERO, 3'h7, 1'b0);
        rd_chk(ADDR_PORT_ZERO, 1'b1, 8'h27, "latch after bit writes");
        settle();
        chk(p0_oe, 8'hD8, "latch drives lows");
        chk(p0_pu, 8'h27, "pull-ups on idle highs");
        p0_an = 8'h01;
        settle();
        chk(p0_pu, 8'h26, "no pull-up on analog");
        p0_an = 8'h00;
        p0_pp = 8'hFF;
        settle();
        chk(p0_oe, 8'hFF, "push-pull drives all");
        chk(p0_out, 8'h27, "push-pull value");
        p0_pp = 8'h00;
        // plain read sees wired-and of latch and outside level
        p0_ext = 8'hF0;
        settle();
        rd_chk(ADDR_PORT_ZERO, 1'b0, 8'h27 & 8'hF0, "pin read, on");
        wr_b(ADDR_ROUTE_B, 8'hC0);
        settle();
        chk(p0_pu, 8'h00, "pull-ups disabled");
        // crossbar off, pins handed to a peripheral: reads still see pins
        wr_b(ADDR_ROUTE_B, 8'h00);
        p0_sel = 8'hFF;
        p0_ext = 8'h5C;
        settle();
        rd_chk(ADDR_PORT_ZERO, 1'b0, 8'h5C, "pin read, routed");
        rd_chk(ADDR_PORT_ZERO, 1'b1, 8'h27, "latch read, routed");
        p0_an = 8'h0C;
        settle();
        rd_chk(ADDR_PORT_ZERO, 1'b0, 8'h50, "analog pins read low");
        p0_an = 8'h00;
        // unmapped place: write ignored, read zero
        wr_b(8'hA0, 8'h55);
        rd_chk(8'hA0, 1'b0, 8'h00, "unmapped read");
        // port zero match, pins still routed away
        p0_ext = 8'h35;
        wr_b(ADDR_P0_CMP, 8'h05);
        wr_b(ADDR_P0_MASK, 8'h0F);
        settle();
        chk({6'h00, irq, wake}, 8'h00, "masked equal");
        p0_ext = 8'h34;
        settle();
        chk({6'h00, irq, wake}, 8'h01, "wake without enable");
        wr_b(ADDR_IRQ_EN2, 8'h02);
        settle();
        chk({6'h00, irq, wake}, 8'h03, "interrupt enabled");
        p0_ext = 8'h35;
        settle();
        chk({6'h00, irq, wake}, 8'h00, "match cleared");
        // port one match on its top bit
        wr_b(ADDR_P1_CMP, 8'h00);
        wr_b(ADDR_P1_MASK, 8'h80);
        p1_ext = 8'h80;
        settle();
        chk({6'h00, irq, wake}, 8'h03, "port one event");
        wr_b(ADDR_IRQ_EN2, 8'h00);
        settle();
        chk({6'h00, irq, wake}, 8'h01, "enable cleared");
        wr_bit(ADDR_PORT_ONE, 3'h0, 1'b0);
        rd_chk(ADDR_PORT_ONE, 1'b0, 8'h80, "port one pins");
        chk(p1_out, 8'hFE, "port one latch");
        chk(p1_pu & ~p1_oe, 8'hFF, "port one pulls");
        results();
    end
endmodule : port_crossbar_and_match_test
